// [mts_sequencer.sv]
// conversion sequencer, standby, alarms and apb registers of the monitor
module mts_sequencer
    import mts_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = SMB_TIMEOUT_CYC
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // pins
    input  wire logic        standby_n_input,
    input  wire logic        smb_scl_in,
    input  wire logic        smb_sda_in,
    output logic             smb_active,
    output logic             smb_reset,
    output logic             overtemp_n_output,
    output logic             alert_n_output,
    output logic             irq,
    // converter
    output logic             conv_clk_en,
    output logic             conv_enable,
    output logic             conv_start,
    output logic             conv_abort,
    output logic [2:0]       conv_channel,
    input  wire logic        conv_done,
    input  wire logic [7:0]  conv_data
);
    mts_conv_state_type state_reg;
    logic [7:0]  config_reg;
    logic [11:0] status_reg;
    logic [11:0] mask_reg;
    logic [7:0]  temp_reg [NUM_CH];
    logic [7:0]  alim_reg [NUM_CH];
    logic [7:0]  otlim_reg [NUM_OT];
    logic [2:0]  idx_reg;
    logic        ch1_turn_reg;
    logic        standby_n_input_s1_reg;
    logic        standby_n_input_s2_reg;
    logic        scl_s1_reg;
    logic        scl_s2_reg;
    logic        sda_s1_reg;
    logic        sda_s2_reg;
    logic        sda_s3_reg;
    logic        armed_reg;
    logic [TO_CNT_W-1:0] to_cnt_reg;
    logic        hw_standby_n_input;
    logic        standby;
    logic [2:0]  cur_ch;
    logic        done_ok;
    logic        setup_ph;
    logic        access_ph;
    logic [31:0] rd_next;
    logic        err_next;
    logic [6:0]  alert_vec;
    logic [3:0]  ot_vec;
    logic [11:0] st_set;
    logic [11:0] st_clr;

    function automatic logic [2:0] seq_chan(input logic [2:0] i);
        unique case (i)
            3'h0:    seq_chan = CH_R1;
            3'h1:    seq_chan = CH_R2;
            3'h2:    seq_chan = CH_R3;
            3'h3:    seq_chan = CH_LOCAL;
            3'h4:    seq_chan = CH_R4;
            3'h5:    seq_chan = CH_R5;
            default: seq_chan = CH_R6;
        endcase
    endfunction

    function automatic logic [2:0] ot_chan(input int k);
        unique case (k)
            0:       ot_chan = CH_R1;
            1:       ot_chan = CH_R4;
            2:       ot_chan = CH_R5;
            default: ot_chan = CH_R6;
        endcase
    endfunction

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            standby_n_input_s1_reg <= 1'b1;
            standby_n_input_s2_reg <= 1'b1;
            scl_s1_reg  <= 1'b1;
            scl_s2_reg  <= 1'b1;
            sda_s1_reg  <= 1'b1;
            sda_s2_reg  <= 1'b1;
            sda_s3_reg  <= 1'b1;
        end
        else
        begin
            standby_n_input_s1_reg <= standby_n_input;
            standby_n_input_s2_reg <= standby_n_input_s1_reg;
            scl_s1_reg  <= smb_scl_in;
            scl_s2_reg  <= scl_s1_reg;
            sda_s1_reg  <= smb_sda_in;
            sda_s2_reg  <= sda_s1_reg;
            sda_s3_reg  <= sda_s2_reg;
        end
    end

    assign hw_standby_n_input  = !standby_n_input_s2_reg;
    assign standby  = hw_standby_n_input || config_reg[CFG_STOP_BIT];
    assign cur_ch   = (config_reg[CFG_FAST_BIT] && ch1_turn_reg) ?
                      CH_R1 : seq_chan(idx_reg);
    assign done_ok  = (state_reg == ST_WAIT) && conv_done && !standby;
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable && pready;

    // conversion control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= ST_IDLE;
            conv_start   <= 1'b0;
            conv_abort   <= 1'b0;
            conv_channel <= CH_R1;
        end
        else
        begin
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (!standby)
                    begin
                        state_reg    <= ST_WAIT;
                        conv_start   <= 1'b1;
                        conv_channel <= cur_ch;
                    end
                end
                ST_WAIT:
                begin
                    if (standby)
                    begin
                        state_reg  <= ST_IDLE;
                        conv_abort <= 1'b1;
                    end
                    else if (conv_done)
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // sequence position; standby restarts at the first channel
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idx_reg      <= 3'h0;
            ch1_turn_reg <= 1'b1;
        end
        else if (standby)
        begin
            // idle standby too, so a resumed or new mode starts cleanly
            idx_reg      <= 3'h0;
            ch1_turn_reg <= 1'b1;
        end
        else if (done_ok)
        begin
            if (config_reg[CFG_FAST_BIT])
            begin
                ch1_turn_reg <= !ch1_turn_reg;
                if (!ch1_turn_reg)
                    idx_reg <= (idx_reg >= SEQ_LAST) ? SEQ_FIRST_OTHER :
                               3'(idx_reg + 3'h1);
                else if (idx_reg == 3'h0)
                    idx_reg <= SEQ_FIRST_OTHER;
            end
            else
            begin
                ch1_turn_reg <= 1'b1;
                idx_reg <= (idx_reg >= SEQ_LAST) ? 3'h0 :
                           3'(idx_reg + 3'h1);
            end
        end
    end

    // temperature results, never touched by standby
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
                temp_reg[i] <= TEMP_RESET;
        end
        else if (done_ok)
        begin
            temp_reg[conv_channel] <= conv_data;
        end
    end

    // converter enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_clk_en <= 1'b0;
            conv_enable <= 1'b0;
        end
        else
        begin
            conv_clk_en <= !hw_standby_n_input;
            conv_enable <= !standby;
        end
    end

    // smbus inactivity timeout
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_reg  <= 1'b0;
            to_cnt_reg <= '0;
            smb_reset  <= 1'b0;
            smb_active <= 1'b0;
        end
        else
        begin
            smb_active <= !hw_standby_n_input;
            smb_reset  <= 1'b0;
            if (hw_standby_n_input)
            begin
                armed_reg  <= 1'b0;
                to_cnt_reg <= '0;
            end
            else if (scl_s2_reg && sda_s3_reg && !sda_s2_reg)
            begin
                armed_reg  <= 1'b1;
                to_cnt_reg <= '0;
            end
            else if (scl_s2_reg && !sda_s3_reg && sda_s2_reg)
            begin
                armed_reg  <= 1'b0;
                to_cnt_reg <= '0;
            end
            else if (armed_reg && !sda_s2_reg)
            begin
                if (to_cnt_reg >= TO_CNT_W'(TIMEOUT_CYCLES - 1))
                begin
                    smb_reset  <= 1'b1;
                    armed_reg  <= 1'b0;
                    to_cnt_reg <= '0;
                end
                else
                    to_cnt_reg <= TO_CNT_W'(to_cnt_reg + 1'b1);
            end
            else
                to_cnt_reg <= '0;
        end
    end

    // threshold compare
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
            alert_vec[i] = temp_reg[i] > alim_reg[i];
        for (int k = 0; k < NUM_OT; k++)
            ot_vec[k] = temp_reg[ot_chan(k)] > otlim_reg[k];
        st_set = '0;
        st_set[ST_ALERT_LSB +: NUM_CH] = alert_vec;
        st_set[ST_OT_LSB +: NUM_OT]    = ot_vec;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overtemp_n_output <= 1'b1;
            alert_n_output    <= 1'b1;
            irq               <= 1'b0;
        end
        else
        begin
            overtemp_n_output <= !(|ot_vec);
            alert_n_output    <= !(|alert_vec);
            irq               <= |(status_reg & mask_reg);
        end
    end

    // apb read decode, evaluated in the setup cycle
    always_comb
    begin
        rd_next  = '0;
        err_next = 1'b0;
        if (paddr == ADDR_CONFIG1)
            rd_next[7:0] = config_reg;
        else if (paddr == ADDR_STATUS)
            rd_next[11:0] = status_reg;
        else if (paddr == ADDR_MASK)
            rd_next[11:0] = mask_reg;
        else if (paddr == ADDR_STATE)
            rd_next[6:0] = {hw_standby_n_input, config_reg[CFG_STOP_BIT],
                            ch1_turn_reg, state_reg, conv_channel};
        else if (paddr >= ADDR_TEMP0 && paddr < ADDR_TEMP0 + 8'h1c
                 && paddr[1:0] == 2'h0)
            rd_next[7:0] = temp_reg[3'((paddr - ADDR_TEMP0) >> 2)];
        else if (paddr >= ADDR_ALIM0 && paddr < ADDR_ALIM0 + 8'h1c
                 && paddr[1:0] == 2'h0)
            rd_next[7:0] = alim_reg[3'((paddr - ADDR_ALIM0) >> 2)];
        else if (paddr >= ADDR_OTLIM0 && paddr < ADDR_OTLIM0 + 8'h10
                 && paddr[1:0] == 2'h0)
            rd_next[7:0] = otlim_reg[2'((paddr - ADDR_OTLIM0) >> 2)];
        else
            err_next = 1'b1;
    end

    // no wait state: answer registered from the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (setup_ph)
        begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_next;
            pslverr <= err_next;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // software registers, written at the completing access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            config_reg <= CFG_RESET;
            mask_reg   <= '0;
            for (int i = 0; i < NUM_CH; i++)
                alim_reg[i] <= ALIM_RESET;
            for (int k = 0; k < NUM_OT; k++)
                otlim_reg[k] <= OTLIM_RESET;
        end
        else if (access_ph && pwrite && !pslverr)
        begin
            if (paddr == ADDR_CONFIG1)
                config_reg <= pwdata[7:0] & CFG_WMASK;
            else if (paddr == ADDR_MASK)
                mask_reg <= pwdata[11:0] & ST_WMASK;
            else if (paddr >= ADDR_ALIM0 && paddr < ADDR_OTLIM0)
                alim_reg[3'((paddr - ADDR_ALIM0) >> 2)] <= pwdata[7:0];
            else if (paddr >= ADDR_OTLIM0)
                otlim_reg[2'((paddr - ADDR_OTLIM0) >> 2)] <= pwdata[7:0];
        end
    end

    // sticky status: read clears, a set in the same cycle wins
    assign st_clr = (access_ph && !pwrite && paddr == ADDR_STATUS) ?
                    status_reg : 12'h000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_reg <= '0;
        else
            status_reg <= (status_reg & ~st_clr) | st_set;
    end

    // checks
    seq_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start && !$past(config_reg[CFG_FAST_BIT])
        && $past(idx_reg) == 3'h3
        |-> conv_channel == CH_LOCAL)
        else $error("local channel not fourth in default order");

    fast_ch1_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_ok && config_reg[CFG_FAST_BIT] && !ch1_turn_reg
        ##1 (!standby && config_reg[CFG_FAST_BIT])
        |=> (conv_start && conv_channel == CH_R1))
        else $error("fast mode did not return to remote 1");

    store_res_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_ok |=> temp_reg[$past(conv_channel)] == $past(conv_data))
        else $error("result not stored to measured channel");

    abort_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == ST_WAIT && standby) |=> conv_abort
        && $stable(temp_reg[conv_channel]))
        else $error("abort altered temperature or gave no abort");

    stop_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        standby [*2] |=> !conv_start && !conv_enable)
        else $error("converter ran in standby");

    hw_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
        hw_standby_n_input |=> !conv_clk_en && !smb_active)
        else $error("hardware standby left clock or smbus on");

    sw_smb_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!hw_standby_n_input && config_reg[CFG_STOP_BIT]) |=> smb_active)
        else $error("smbus inactive in software standby");

    to_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        !armed_reg && !(scl_s2_reg && sda_s3_reg && !sda_s2_reg)
        |=> !armed_reg && !smb_reset)
        else $error("timeout armed without start");

    overtemp_n_output_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|ot_vec) |=> !overtemp_n_output)
        else $error("overtemp output not asserted");

    alert_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        (alert_vec == 7'h00) |=> alert_n_output)
        else $error("alert output asserted without cause");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|(status_reg & mask_reg)) |=> irq)
        else $error("interrupt not raised for masked status");

    conv_done_c: cover property (@(posedge pclk) disable iff (!presetn)
        done_ok);
    fast_run_c: cover property (@(posedge pclk) disable iff (!presetn)
        done_ok && config_reg[CFG_FAST_BIT]);
    abort_c: cover property (@(posedge pclk) disable iff (!presetn)
        conv_abort);
    timeout_c: cover property (@(posedge pclk) disable iff (!presetn)
        smb_reset);
endmodule

// [mts_pkg.sv]
// constants, register map and types of the temperature sequencer
package mts_pkg;
    // clock and timing
    localparam int CLK_HZ           = 40_000_000;
    localparam int SMB_TIMEOUT_MS   = 25;
    localparam int SMB_TIMEOUT_CYC  = SMB_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int TO_CNT_W         = 21;

    // channels: 0 is local, 1..6 remote
    localparam int NUM_CH           = 7;
    localparam int NUM_OT           = 4;
    localparam logic [2:0] CH_LOCAL = 3'h0;
    localparam logic [2:0] CH_R1    = 3'h1;
    localparam logic [2:0] CH_R2    = 3'h2;
    localparam logic [2:0] CH_R3    = 3'h3;
    localparam logic [2:0] CH_R4    = 3'h4;
    localparam logic [2:0] CH_R5    = 3'h5;
    localparam logic [2:0] CH_R6    = 3'h6;
    localparam logic [2:0] SEQ_LAST = 3'h6;
    localparam logic [2:0] SEQ_FIRST_OTHER = 3'h1;

    // register byte addresses
    localparam logic [7:0] ADDR_CONFIG1  = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_MASK     = 8'h08;
    localparam logic [7:0] ADDR_STATE    = 8'h0c;
    localparam logic [7:0] ADDR_TEMP0    = 8'h10;
    localparam logic [7:0] ADDR_ALIM0    = 8'h30;
    localparam logic [7:0] ADDR_OTLIM0   = 8'h50;

    // config1 fields
    localparam int CFG_FAST_BIT     = 4;
    localparam int CFG_STOP_BIT     = 6;
    localparam logic [7:0] CFG_WMASK = 8'h50;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // status and mask layout: alert per channel, overtemp per ot channel
    localparam int ST_ALERT_LSB     = 0;
    localparam int ST_OT_LSB        = 8;
    localparam logic [11:0] ST_WMASK = 12'hf7f;

    // reset values of limits and temperature results
    localparam logic [7:0] ALIM_RESET  = 8'h55;
    localparam logic [7:0] OTLIM_RESET = 8'h6e;
    localparam logic [7:0] TEMP_RESET  = 8'h00;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } mts_conv_state_type;
endpackage

// [mts_conv_model.sv]
// converter model that answers conversion requests of the sequencer
module mts_conv_model
    import mts_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // requests from the sequencer
    input  wire logic       conv_start,
    input  wire logic       conv_abort,
    input  wire logic       conv_enable,
    input  wire logic [2:0] conv_channel,
    // bench knobs: answer delay and result base
    input  wire logic [7:0] dly,
    input  wire logic [7:0] base,
    // answer
    output logic            conv_done,
    output logic [7:0]      conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       busy;
    logic [7:0] cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy      <= 1'b0;
            cnt       <= 8'h00;
            conv_done <= 1'b0;
            conv_data <= 8'h00;
        end
        else
        begin
            conv_done <= 1'b0;
            // data is only valid with done; toggle so it is never reused
            conv_data <= ~conv_data;
            if (conv_abort || !conv_enable)
                busy <= 1'b0;
            else if (conv_start)
            begin
                busy <= 1'b1;
                cnt  <= dly;
            end
            else if (busy && cnt == 8'h00)
            begin
                busy      <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= base + {5'h00, conv_channel};
            end
            else if (busy)
                cnt <= cnt - 8'h01;
        end
    end
endmodule

// [tb.sv]
// self-checking bench of the temperature sequencer
module tb
    import mts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        standby_n_input = 1, scl = 1, sda = 1;
    logic        smb_active, smb_reset, ot_n, al_n, irq;
    logic        clk_en, en, start, abort, done;
    logic [2:0]  chan, ch;
    logic [7:0]  cdata, dly = 8'h01, base = 8'h20;
    int          num_errors = 0, cmp_count = 0, starts = 0, resets = 0, n;
    int          aborts = 0;
    logic [2:0]  dseq [7] = '{1, 2, 3, 0, 4, 5, 6};
    logic [2:0]  fseq [12] = '{1, 2, 1, 3, 1, 0, 1, 4, 1, 5, 1, 6};

    mts_sequencer #(.TIMEOUT_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .standby_n_input(standby_n_input),
        .smb_scl_in(scl), .smb_sda_in(sda), .smb_active(smb_active),
        .smb_reset(smb_reset), .overtemp_n_output(ot_n),
        .alert_n_output(al_n), .irq(irq), .conv_clk_en(clk_en),
        .conv_enable(en), .conv_start(start), .conv_abort(abort),
        .conv_channel(chan), .conv_done(done), .conv_data(cdata));
    mts_conv_model model (.pclk(pclk), .presetn(presetn),
        .conv_start(start), .conv_abort(abort), .conv_enable(en),
        .conv_channel(chan), .dly(dly), .base(base), .conv_done(done),
        .conv_data(cdata));

    initial
    begin
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        starts <= starts + int'(start === 1'b1);
        resets <= resets + int'(smb_reset === 1'b1);
        aborts <= aborts + int'(abort === 1'b1);
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            k++;
            @(posedge pclk);
        end
        chk("apb ready", 1, 32'(pready === 1'b1));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic get_start();
        int k;
        k = 0;
        @(posedge pclk);
        while (start !== 1'b1 && k < 200)
        begin
            k++;
            @(posedge pclk);
        end
        chk("start seen", 1, 32'(start === 1'b1));
        ch = chan;
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #1000000;
        num_errors++;
        test_done();
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // conversions run from reset, so the order is watched first
        for (int i = 0; i < 8; i++)
        begin
            get_start();
            chk("default order", 32'(dseq[i % 7]), 32'(ch));
        end
        for (int i = 0; i < 7; i++)
        begin
            xfer(0, ADDR_TEMP0 + 8'(4 * i), 0);
            chk("temp", 32'h20 + i, rd);
        end
        xfer(0, ADDR_CONFIG1, 0);
        chk("cfg", {24'h0, CFG_RESET}, rd);
        xfer(0, ADDR_ALIM0 + 8'h0c, 0);
        chk("alim3", {24'h0, ALIM_RESET}, rd);
        xfer(0, ADDR_OTLIM0 + 8'h0c, 0);
        chk("otlim6", {24'h0, OTLIM_RESET}, rd);
        xfer(0, 8'hfc, 0);
        chk("unmapped err", 1, 32'(err));
        // stop with fast selected, then release so fast starts cleanly
        xfer(1, ADDR_CONFIG1, 32'h50);
        repeat (5) @(posedge pclk);
        n = starts;
        repeat (20) @(posedge pclk);
        chk("soft standby_n_input starts", n, starts);
        chk("soft standby_n_input enable", 0, 32'(en));
        xfer(0, ADDR_CONFIG1, 0);
        chk("cfg in standby_n_input", 32'h50, rd);
        xfer(0, ADDR_TEMP0 + 8'h08, 0);
        chk("temp kept soft", 32'h22, rd);
        xfer(1, ADDR_CONFIG1, 32'h10);
        for (int i = 0; i < 12; i++)
        begin
            get_start();
            chk("fast order", 32'(fseq[i]), 32'(ch));
        end
        xfer(1, ADDR_CONFIG1, 32'h00);
        // abort: a late result would carry the new base
        dly <= 8'h0a;
        get_start();
        base <= 8'h40;
        standby_n_input <= 1'b0;
        n = aborts;
        repeat (8) @(posedge pclk);
        chk("hw standby_n_input abort", n + 1, aborts);
        chk("hw standby_n_input clk", 0, 32'(clk_en));
        chk("hw standby_n_input smb", 0, 32'(smb_active));
        n = starts;
        repeat (20) @(posedge pclk);
        chk("hw standby_n_input starts", n, starts);
        xfer(0, ADDR_TEMP0 + 8'(4 * ch), 0);
        chk("temp kept abort", 32'h20 + 32'(ch), rd);
        standby_n_input <= 1'b1;
        get_start();
        chk("restart ch", 32'(CH_R1), 32'(ch));
        chk("smb back", 1, 32'(smb_active));
        dly <= 8'h01;
        // alarms on the local channel and remote 1
        xfer(1, ADDR_ALIM0, 32'h10);
        xfer(1, ADDR_OTLIM0, 32'h10);
        xfer(1, ADDR_MASK, 32'h001);
        repeat (60) @(posedge pclk);
        chk("alert low", 0, 32'(al_n));
        chk("ot low", 0, 32'(ot_n));
        chk("irq", 1, 32'(irq));
        xfer(0, ADDR_STATUS, 0);
        chk("status", 32'h101, rd);
        xfer(1, ADDR_ALIM0, 32'hff);
        xfer(1, ADDR_OTLIM0 + 8'h04, 32'h10);
        xfer(1, ADDR_OTLIM0, 32'hff);
        repeat (60) @(posedge pclk);
        xfer(0, ADDR_STATUS, 0);
        repeat (3) @(posedge pclk);
        chk("alert high", 1, 32'(al_n));
        chk("irq clear", 0, 32'(irq));
        chk("ot remote4", 0, 32'(ot_n));
        // sda low with no start must not time out
        scl <= 1'b0;
        sda <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("no arm", 0, resets);
        sda <= 1'b1;
        scl <= 1'b1;
        repeat (5) @(posedge pclk);
        sda <= 1'b0;
        n = 0;
        while (resets == 0 && n < 60)
        begin
            n++;
            @(posedge pclk);
        end
        chk("timeout span", 1, 32'(n >= 20 && n <= 30));
        sda <= 1'b1;
        test_done();
    end
endmodule
